// ---- include/ucf_pkg.sv ----
package ucf_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTL0 = 12'hf42;
  localparam logic [11:0] IDX_CTL1 = 12'hf43;
  localparam logic [11:0] IDX_ADDR_CMP = 12'hf45;
  localparam logic [11:0] IDX_BAUD_HI = 12'hf46;
  localparam logic [11:0] IDX_BAUD_LO = 12'hf47;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hf49;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'hf4a;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'hf4b;
  // control 0 fields used here
  localparam int CTL0_RX_ENABLE = 6;
  localparam int CTL0_PARITY_ON = 4;
  // control 1 fields
  localparam int CTL1_MODE_HI = 7;
  localparam int CTL1_NINE_BIT_ENABLE = 6;
  localparam int CTL1_MODE_LO = 5;
  localparam int CTL1_NINTH_BIT_TX_VALUE = 4;
  localparam int CTL1_DRIVER_ENABLE_POLARITY = 3;
  localparam int CTL1_BAUD_READBACK_IRQ_CTRL = 2;
  localparam int CTL1_RX_DATA_IRQ_GATE = 1;
  localparam int CTL1_INFRARED_PATH_ENABLE = 0;
  // interrupt status bits
  localparam int IRQ_RX_DATA = 0;
  localparam int IRQ_RX_ERROR = 1;
  localparam int IRQ_BAUD_TICK = 2;
  localparam int IRQ_BITS = 3;
  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] ADDR_CMP_RESET = 8'h00;
  localparam logic [7:0] BAUD_BYTE_RESET = 8'hff;
  localparam logic [IRQ_BITS-1:0] IRQ_RESET = 3'h0;
  // address filter policies
  typedef enum logic [1:0] {
    UCF_FILTER_ALL = 2'b00,
    UCF_FILTER_ADDR_ONLY = 2'b01,
    UCF_FILTER_MATCH_RUN = 2'b10,
    UCF_FILTER_MATCH_DATA = 2'b11
  } ucf_filter_e;
  // one received character from the deserialiser
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic ninth;
    logic error;
  } ucf_rx_char_s;
  // transmit framing controls toward the serialiser
  typedef struct packed {
    logic nineBitFrame;
    logic ninthBit;
    logic parityOn;
  } ucf_tx_frame_s;
endpackage

// ---- core/ucf_uart_control_one.sv ----
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - nine-bit enable switches to nine-bit framing; clear returns ordinary framing
// - mode 00: interrupt on every received byte, address or data
// - mode 01: interrupt only on address bytes
// - mode 10: interrupt on matching address and following data until mismatch
// - mode 11: interrupt only on data after a matching address
// - in nine-bit mode transmit ninth bit comes from the field
// - driver enable active high when polarity zero, active low when one
// - receiver off and baud control set: counter zero raises baud tick interrupt
// - baud byte reads give reload when control zero, live count when one
// - low byte read does not latch high byte
// - gate zero: data and errors interrupt; gate one: only errors
// - infrared field routes serial data through the encoder and decoder
// - nine-bit mode overrides parity enable
// - upper mode bit: address bytes compared, interrupts and availability only on match
module ucf_uart_control_one #(
  parameter int BAUD_WIDTH = 16
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive and transmit cores
  input wire ucf_pkg::ucf_rx_char_s rxChar,
  input wire logic txActive,
  output ucf_pkg::ucf_tx_frame_s txFrame,
  output logic rxByteAvailable,
  output logic baudTick,
  // serial path
  input wire logic txSerial,
  input wire logic irEncodedTx,
  input wire logic rxPin,
  input wire logic irDecodedRx,
  output logic txPin,
  output logic rxToCore,
  output logic lineDriverEnable,
  // interrupt
  output logic irq
);
  logic [7:0] ctl0;
  logic [7:0] ctl1;
  logic [7:0] addrCompare;
  logic [15:0] baudReload;
  logic [BAUD_WIDTH-1:0] baudDividerCounter;
  logic [ucf_pkg::IRQ_BITS-1:0] irqStatus;
  logic [ucf_pkg::IRQ_BITS-1:0] irqEnable;
  logic lastAddrMatched;
  logic busReq;
  logic wrStrobe;
  logic [11:0] regIdx;
  logic nineBitEnable;
  logic rxEnabled;
  logic baudReadbackIrqCtrl;
  ucf_pkg::ucf_filter_e addrFilterMode;
  logic isAddrByte;
  logic addrMatch;
  logic passByte;
  logic rxDataEvent;
  logic [ucf_pkg::IRQ_BITS-1:0] setEvents;
  logic [ucf_pkg::IRQ_BITS-1:0] clearMask;
  logic [15:0] baudView;
  logic [7:0] next_readByte;

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStrobe = busReq && wb_we_i && wb_sel_i[0];
  assign regIdx = wb_adr_i[13:2];
  assign nineBitEnable = ctl1[ucf_pkg::CTL1_NINE_BIT_ENABLE];
  assign rxEnabled = ctl0[ucf_pkg::CTL0_RX_ENABLE];
  assign baudReadbackIrqCtrl = ctl1[ucf_pkg::CTL1_BAUD_READBACK_IRQ_CTRL];
  assign addrFilterMode = ucf_pkg::ucf_filter_e'({ctl1[ucf_pkg::CTL1_MODE_HI],
                                                  ctl1[ucf_pkg::CTL1_MODE_LO]});
  assign isAddrByte = nineBitEnable && rxChar.ninth;
  assign addrMatch = rxChar.data == addrCompare;

  // decides whether a received character is passed on and interrupts
  always_comb
  begin
    passByte = 1'b1;
    if (nineBitEnable)
    begin
      case (addrFilterMode)
        ucf_pkg::UCF_FILTER_ALL: passByte = 1'b1;
        ucf_pkg::UCF_FILTER_ADDR_ONLY: passByte = isAddrByte;
        ucf_pkg::UCF_FILTER_MATCH_RUN:
          passByte = isAddrByte ? addrMatch : lastAddrMatched;
        ucf_pkg::UCF_FILTER_MATCH_DATA:
          passByte = !isAddrByte && lastAddrMatched;
        default: passByte = 1'b0;
      endcase
    end
  end

  assign rxDataEvent = rxChar.valid && !rxChar.error && passByte;
  assign clearMask = (wrStrobe && regIdx == ucf_pkg::IDX_IRQ_CLEAR) ?
                     wb_dat_i[ucf_pkg::IRQ_BITS-1:0] : ucf_pkg::IRQ_RESET;
  assign baudView = baudReadbackIrqCtrl ? baudDividerCounter[15:0] : baudReload;

  always_comb
  begin
    setEvents = ucf_pkg::IRQ_RESET;
    setEvents[ucf_pkg::IRQ_RX_DATA] = rxDataEvent &&
                                      !ctl1[ucf_pkg::CTL1_RX_DATA_IRQ_GATE];
    setEvents[ucf_pkg::IRQ_RX_ERROR] = rxChar.valid && rxChar.error;
    setEvents[ucf_pkg::IRQ_BAUD_TICK] = baudTick && !rxEnabled && baudReadbackIrqCtrl;
  end

  always_comb
  begin
    next_readByte = 8'h00;
    case (regIdx)
      ucf_pkg::IDX_CTL0: next_readByte = ctl0;
      ucf_pkg::IDX_CTL1: next_readByte = ctl1;
      ucf_pkg::IDX_ADDR_CMP: next_readByte = addrCompare;
      ucf_pkg::IDX_BAUD_HI: next_readByte = baudView[15:8];
      ucf_pkg::IDX_BAUD_LO: next_readByte = baudView[7:0];
      ucf_pkg::IDX_IRQ_STATUS: next_readByte = {5'h00, irqStatus};
      ucf_pkg::IDX_IRQ_ENABLE: next_readByte = {5'h00, irqEnable};
      default: next_readByte = 8'h00;
    endcase
  end

  // bus answer one cycle after the request
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (clkEnable)
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? {24'h000000, next_readByte} : 32'h00000000;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctl0 <= ucf_pkg::CTL_RESET;
      ctl1 <= ucf_pkg::CTL_RESET;
      addrCompare <= ucf_pkg::ADDR_CMP_RESET;
      baudReload <= {ucf_pkg::BAUD_BYTE_RESET, ucf_pkg::BAUD_BYTE_RESET};
      irqEnable <= ucf_pkg::IRQ_RESET;
    end
    else if (clkEnable && wrStrobe)
    begin
      case (regIdx)
        ucf_pkg::IDX_CTL0: ctl0 <= wb_dat_i[7:0];
        ucf_pkg::IDX_CTL1: ctl1 <= wb_dat_i[7:0];
        ucf_pkg::IDX_ADDR_CMP: addrCompare <= wb_dat_i[7:0];
        ucf_pkg::IDX_BAUD_HI: baudReload[15:8] <= wb_dat_i[7:0];
        ucf_pkg::IDX_BAUD_LO: baudReload[7:0] <= wb_dat_i[7:0];
        ucf_pkg::IDX_IRQ_ENABLE: irqEnable <= wb_dat_i[ucf_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // baud down-counter, reloads on reaching zero
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      baudDividerCounter <= BAUD_WIDTH'({ucf_pkg::BAUD_BYTE_RESET, ucf_pkg::BAUD_BYTE_RESET});
      baudTick <= 1'b0;
    end
    else if (clkEnable)
    begin
      baudTick <= baudDividerCounter == '0;
      if (baudDividerCounter == '0)
        baudDividerCounter <= BAUD_WIDTH'(baudReload);
      else
        baudDividerCounter <= baudDividerCounter - 1'b1;
    end
  end

  // remembers whether the latest address byte matched
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      lastAddrMatched <= 1'b0;
    else if (clkEnable && rxChar.valid && !rxChar.error && isAddrByte)
      lastAddrMatched <= addrMatch;
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irqStatus <= ucf_pkg::IRQ_RESET;
    else if (clkEnable)
      irqStatus <= (irqStatus & ~clearMask) | setEvents;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq <= 1'b0;
      rxByteAvailable <= 1'b0;
    end
    else if (clkEnable)
    begin
      irq <= |(((irqStatus & ~clearMask) | setEvents) & irqEnable);
      rxByteAvailable <= rxDataEvent;
    end
  end

  // framing, driver enable and serial routing
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      txFrame <= '0;
      lineDriverEnable <= 1'b0;
      txPin <= 1'b1;
      rxToCore <= 1'b1;
    end
    else if (clkEnable)
    begin
      txFrame.nineBitFrame <= nineBitEnable;
      txFrame.ninthBit <= nineBitEnable && ctl1[ucf_pkg::CTL1_NINTH_BIT_TX_VALUE];
      txFrame.parityOn <= ctl0[ucf_pkg::CTL0_PARITY_ON] && !nineBitEnable;
      lineDriverEnable <= txActive ^ ctl1[ucf_pkg::CTL1_DRIVER_ENABLE_POLARITY];
      txPin <= ctl1[ucf_pkg::CTL1_INFRARED_PATH_ENABLE] ? irEncodedTx : txSerial;
      rxToCore <= ctl1[ucf_pkg::CTL1_INFRARED_PATH_ENABLE] ? irDecodedRx : rxPin;
    end
  end

  AST_NINTH_BIT: assert property (@(posedge sys_clk) disable iff (reset)
    clkEnable |=> (txFrame.ninthBit == ($past(nineBitEnable) &&
      $past(ctl1[ucf_pkg::CTL1_NINTH_BIT_TX_VALUE]))))
    else $error("ninth bit does not follow field");
  AST_PARITY_OVERRIDE: assert property (@(posedge sys_clk) disable iff (reset)
    txFrame.nineBitFrame |-> !txFrame.parityOn)
    else $error("parity active in nine-bit mode");
  AST_DRIVER_POL: assert property (@(posedge sys_clk) disable iff (reset)
    clkEnable |=> lineDriverEnable == ($past(txActive) ^
      $past(ctl1[ucf_pkg::CTL1_DRIVER_ENABLE_POLARITY])))
    else $error("driver enable polarity wrong");
  AST_ADDR_ONLY: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEnable && nineBitEnable && addrFilterMode == ucf_pkg::UCF_FILTER_ADDR_ONLY
      && rxChar.valid && !rxChar.ninth) |=> !rxByteAvailable)
    else $error("data byte passed in address-only mode");
  AST_MATCH_DATA: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEnable && nineBitEnable && addrFilterMode == ucf_pkg::UCF_FILTER_MATCH_DATA
      && rxChar.valid && rxChar.ninth) |=> !rxByteAvailable)
    else $error("address byte passed in match-data mode");
  AST_ALL_BYTES: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEnable && (!nineBitEnable || addrFilterMode == ucf_pkg::UCF_FILTER_ALL)
      && rxChar.valid && !rxChar.error) |=> rxByteAvailable)
    else $error("byte dropped in pass-all mode");
  AST_DATA_GATE: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEnable && ctl1[ucf_pkg::CTL1_RX_DATA_IRQ_GATE] && !irqStatus[ucf_pkg::IRQ_RX_DATA]
      && !rxChar.error) |=> !irqStatus[ucf_pkg::IRQ_RX_DATA])
    else $error("gated data raised interrupt");
  AST_BAUD_IRQ: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEnable && baudTick && !rxEnabled && baudReadbackIrqCtrl)
      |=> irqStatus[ucf_pkg::IRQ_BAUD_TICK])
    else $error("baud tick did not set status");
  AST_MATCH_RUN: assert property (@(posedge sys_clk) disable iff (reset)
    (clkEnable && nineBitEnable && addrFilterMode == ucf_pkg::UCF_FILTER_MATCH_RUN
      && rxChar.valid && !rxChar.error && rxChar.ninth && !addrMatch) |=> !rxByteAvailable)
    else $error("mismatched address passed");
endmodule
`default_nettype wire

// ---- tb/ucf_remote_node.sv ----
`timescale 1ns/1ps
`default_nettype none
module ucf_remote_node (
  // clock
  input wire logic sys_clk,
  // line side
  output ucf_pkg::ucf_rx_char_s rxChar,
  output logic rxPin
);
  initial
  begin
    rxChar = '0;
    rxPin = 1'b1;
  end
  // one character per call, then stale content scrambled
  task automatic send(input logic n, input logic [7:0] d, input logic e);
    rxChar <= {1'b1, d, n, e};
    @(posedge sys_clk);
    rxChar <= {1'b0, ~d, ~n, ~e};
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic txActive = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] sel = 4'h1;
  int w;
  logic [15:0] adr = 16'h0000;
  logic [31:0] datI = 32'h00000000;
  logic [31:0] datO;
  logic ack, avail, baudTick, txPin, rxToCore, lineDriverEnable, irq, rxPin;
  ucf_pkg::ucf_rx_char_s rxChar;
  ucf_pkg::ucf_tx_frame_s txFrame;
  logic [7:0] q, q2;
  logic [7:0] c;
  logic [18:0] rows [0:12];
  int miscompares = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  ucf_uart_control_one #(.BAUD_WIDTH(16)) u_ucf_uart_control_one (.sys_clk(sys_clk),
    .reset(reset), .clkEnable(clkEn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .rxChar(rxChar), .txActive(txActive), .txFrame(txFrame), .rxByteAvailable(avail),
    .baudTick(baudTick), .txSerial(1'b0), .irEncodedTx(1'b1), .rxPin(rxPin),
    .irDecodedRx(1'b0), .txPin(txPin), .rxToCore(rxToCore),
    .lineDriverEnable(lineDriverEnable), .irq(irq));
  ucf_remote_node u_ucf_remote_node (.sys_clk(sys_clk), .rxChar(rxChar), .rxPin(rxPin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
    output logic [7:0] r);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    datI <= {24'h000000, d};
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    r = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 20)
    begin
      miscompares++;
      final_report();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, q);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic rx(input logic n, input logic [7:0] d, input logic e);
    u_ucf_remote_node.send(n, d, e);
    @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
  initial
  begin
    rows = '{{8'h40, 1'b1, 8'h33, 1'b0, 1'b1}, {8'h50, 1'b0, 8'h11, 1'b0, 1'b1},
      {8'h60, 1'b1, 8'h33, 1'b0, 1'b1}, {8'h60, 1'b0, 8'h11, 1'b0, 1'b0},
      {8'hc0, 1'b0, 8'h11, 1'b0, 1'b0}, {8'hc0, 1'b1, 8'h5a, 1'b0, 1'b1},
      {8'hc0, 1'b0, 8'h11, 1'b0, 1'b1}, {8'hc0, 1'b1, 8'h33, 1'b0, 1'b0},
      {8'hc0, 1'b0, 8'h11, 1'b0, 1'b0}, {8'he0, 1'b1, 8'h5a, 1'b0, 1'b0},
      {8'he0, 1'b0, 8'h11, 1'b0, 1'b1}, {8'hb0, 1'b1, 8'h33, 1'b0, 1'b1},
      {8'h40, 1'b0, 8'h11, 1'b1, 1'b0}};
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(ucf_pkg::IDX_CTL1, 8'h00);
    rdc(ucf_pkg::IDX_BAUD_LO, 8'hff);
    rdc(ucf_pkg::IDX_IRQ_STATUS, 8'h00);
    wr(ucf_pkg::IDX_CTL1, 8'ha5);
    rdc(ucf_pkg::IDX_CTL1, 8'ha5);
    sel <= 4'h0;
    wr(ucf_pkg::IDX_CTL1, 8'h00);
    sel <= 4'h1;
    rdc(ucf_pkg::IDX_CTL1, 8'ha5);
    rdc(12'h000, 8'h00);
    $display("registers done");
    wr(ucf_pkg::IDX_CTL0, 8'h10);
    wr(ucf_pkg::IDX_ADDR_CMP, 8'h5a);
    for (int k = 0; k <= 12; k++)
    begin
      c = rows[k][18:11];
      wr(ucf_pkg::IDX_CTL1, c);
      rx(rows[k][10], rows[k][9:2], rows[k][1]);
      chk(avail, rows[k][0]);
      chk(txFrame, {c[6], c[6] & c[4], ~c[6]});
    end
    $display("filter table done");
    wr(ucf_pkg::IDX_IRQ_ENABLE, 8'h03);
    wr(ucf_pkg::IDX_CTL1, 8'h42);
    wr(ucf_pkg::IDX_IRQ_CLEAR, 8'h07);
    rx(1'b0, 8'h11, 1'b0);
    chk(irq, 1'b0);
    rx(1'b0, 8'h11, 1'b1);
    chk(irq, 1'b1);
    wr(ucf_pkg::IDX_IRQ_CLEAR, 8'h07);
    chk(irq, 1'b0);
    wr(ucf_pkg::IDX_CTL1, 8'h40);
    rx(1'b0, 8'h11, 1'b0);
    chk(irq, 1'b1);
    rdc(ucf_pkg::IDX_IRQ_STATUS, 8'h01);
    wr(ucf_pkg::IDX_IRQ_ENABLE, 8'h00);
    chk(irq, 1'b0);
    clkEn <= 1'b0;
    rx(1'b0, 8'h11, 1'b0);
    chk(avail, 1'b0);
    clkEn <= 1'b1;
    $display("interrupt done");
    txActive <= 1'b1;
    wr(ucf_pkg::IDX_CTL1, 8'h00);
    chk(lineDriverEnable, 1'b1);
    chk(txPin, 1'b0);
    chk(rxToCore, 1'b1);
    wr(ucf_pkg::IDX_CTL1, 8'h09);
    chk(lineDriverEnable, 1'b0);
    chk(txPin, 1'b1);
    chk(rxToCore, 1'b0);
    txActive <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(lineDriverEnable, 1'b1);
    $display("pins done");
    wr(ucf_pkg::IDX_BAUD_HI, 8'h00);
    wr(ucf_pkg::IDX_BAUD_LO, 8'h05);
    wr(ucf_pkg::IDX_CTL1, 8'h00);
    rdc(ucf_pkg::IDX_BAUD_LO, 8'h05);
    wr(ucf_pkg::IDX_IRQ_CLEAR, 8'h07);
    wr(ucf_pkg::IDX_IRQ_ENABLE, 8'h04);
    // counter still runs down from its reset value before the first reload
    w = 0;
    while (baudTick !== 1'b1 && w < 70000)
    begin
      @(posedge sys_clk);
      w++;
    end
    if (w >= 70000)
    begin
      miscompares++;
      final_report();
    end
    chk(baudTick, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    wr(ucf_pkg::IDX_CTL1, 8'h04);
    wb(1'b0, ucf_pkg::IDX_BAUD_LO, 8'h00, q);
    wb(1'b0, ucf_pkg::IDX_BAUD_LO, 8'h00, q2);
    chk(q === q2, 1'b0);
    chk(q2 <= 8'h05, 1'b1);
    rdc(ucf_pkg::IDX_BAUD_HI, 8'h00);
    chk(irq, 1'b1);
    wr(ucf_pkg::IDX_CTL0, 8'h50);
    wr(ucf_pkg::IDX_IRQ_CLEAR, 8'h07);
    repeat (10) @(posedge sys_clk);
    chk(irq, 1'b0);
    $display("baud done");
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    chk(irq, 1'b0);
    chk(txFrame, 3'h0);
    rdc(ucf_pkg::IDX_CTL1, 8'h00);
    rdc(ucf_pkg::IDX_CTL0, 8'h00);
    rdc(ucf_pkg::IDX_BAUD_LO, 8'hff);
    $display("reset done");
    final_report();
  end
endmodule
`default_nettype wire
